/* core/kpcfg_config_reg.sv */
// configuration register, alert interrupt and automatic sound launch
`timescale 1ns/10ps
module kpcfg_config_reg
  import kpcfg_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  input wire logic alert_in,
  input wire logic key_debounced_in,
  input wire logic scan_int_tick_in,
  input wire logic key_int_in,
  input wire logic fifo_empty_in,
  input wire logic serial_sound_in,
  input wire logic sound_done_in,
  input wire logic [7:0] key_sound_value_in,
  input wire logic [7:0] alert_sound_value_in,
  output logic sound_valid_out,
  output logic [7:0] sound_cmd_out,
  output logic bus_timeout_en_out,
  output logic scan_run_out,
  output logic sounder_run_out,
  output logic int_n_out
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] cfg_reg, cfg_next;
  logic [1:0] src_reg, src_next;
  logic alert_q_reg, alert_q_next;
  logic alert_wait_reg, alert_wait_next;
  logic alert_int_reg, alert_int_next;
  logic key_int_reg, key_int_next;
  logic snd_valid_reg, snd_valid_next;
  logic [7:0] snd_cmd_reg, snd_cmd_next;
  logic [7:0] rdata_reg, rdata_next;
  logic cfg_wr, int_rd, running, alert_fall, key_snd, alert_snd;

  assign cfg_wr = reg_write_in && (reg_addr_in == KPCFG_CFG_ADDR);
  assign int_rd = reg_read_in && (reg_addr_in == KPCFG_INT_ADDR);
  assign running = cfg_reg[KPCFG_RUN_BIT];
  assign alert_fall = alert_q_reg && !alert_in;
  // automatic sounds only while running; key sound wins a tie
  assign key_snd = running && cfg_reg[KPCFG_KEY_SND_EN_BIT] && key_debounced_in;
  assign alert_snd = running && cfg_reg[KPCFG_ALERT_SND_EN_BIT] && alert_fall;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    cfg_next = cfg_reg;
    src_next = src_reg;
    alert_q_next = alert_in;
    alert_wait_next = alert_wait_reg;
    alert_int_next = alert_int_reg;
    key_int_next = key_int_reg;
    snd_valid_next = 1'b0;
    snd_cmd_next = snd_cmd_reg;
    rdata_next = rdata_reg;
    // source bits never take write data
    if (cfg_wr) begin
      cfg_next = (reg_wdata_in & KPCFG_WRITE_MASK) | (cfg_reg & ~KPCFG_WRITE_MASK);
    end
    // source tracking: done clears, a new launch overrides
    if (sound_done_in) begin
      src_next = KPCFG_SRC_NONE;
    end
    if (serial_sound_in) begin
      src_next = KPCFG_SRC_SERIAL;
    end
    if (alert_snd) begin
      src_next = KPCFG_SRC_ALERT;
      snd_valid_next = 1'b1;
      snd_cmd_next = alert_sound_value_in;
    end
    if (key_snd) begin
      src_next = KPCFG_SRC_KEY;
      snd_valid_next = 1'b1;
      snd_cmd_next = key_sound_value_in;
    end
    // alert interrupt: read clears, a new event in the same cycle wins
    if (int_rd) begin
      alert_int_next = 1'b0;
    end
    if (!running) begin
      alert_wait_next = 1'b0;
      alert_int_next = 1'b0;
    end else if (cfg_reg[KPCFG_ALERT_INT_EN_BIT] && alert_fall) begin
      if (cfg_reg[KPCFG_ALERT_NOW_BIT]) begin
        alert_int_next = 1'b1;
      end else begin
        alert_wait_next = 1'b1;
      end
    end
    // deferred alert interrupt waits for the key-scan interrupt tick
    if (running && alert_wait_reg && scan_int_tick_in) begin
      alert_int_next = 1'b1;
      alert_wait_next = 1'b0;
    end
    // key interrupt only drops once the fifo is empty, reads do not touch it
    if (key_int_in) begin
      key_int_next = 1'b1;
    end else if (fifo_empty_in) begin
      key_int_next = 1'b0;
    end
    // read data captured on the read strobe
    if (reg_read_in) begin
      rdata_next = 8'h00;
      if (reg_addr_in == KPCFG_CFG_ADDR) begin
        rdata_next = {cfg_reg[7:3], src_reg, cfg_reg[KPCFG_TIMEOUT_DIS_BIT]};
      end else if (reg_addr_in == KPCFG_INT_ADDR) begin
        rdata_next[KPCFG_INT_STAT_BIT] = alert_int_reg || key_int_reg;
        rdata_next[KPCFG_INT_ALERT_BIT] = alert_int_reg;
        rdata_next[KPCFG_INT_KEY_BIT] = key_int_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_reg <= KPCFG_CFG_RESET;
      src_reg <= KPCFG_SRC_NONE;
      alert_q_reg <= 1'b1;
      alert_wait_reg <= 1'b0;
      alert_int_reg <= 1'b0;
      key_int_reg <= 1'b0;
      snd_valid_reg <= 1'b0;
      snd_cmd_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end else begin
      cfg_reg <= cfg_next;
      src_reg <= src_next;
      alert_q_reg <= alert_q_next;
      alert_wait_reg <= alert_wait_next;
      alert_int_reg <= alert_int_next;
      key_int_reg <= key_int_next;
      snd_valid_reg <= snd_valid_next;
      snd_cmd_reg <= snd_cmd_next;
      rdata_reg <= rdata_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // shutdown holds the interrupt pin released whatever is pending
  assign int_n_out = !(running && (alert_int_reg || key_int_reg));
  assign bus_timeout_en_out = !cfg_reg[KPCFG_TIMEOUT_DIS_BIT];
  assign scan_run_out = running;
  assign sounder_run_out = running;
  assign sound_valid_out = snd_valid_reg;
  assign sound_cmd_out = snd_cmd_reg;
  assign reg_rdata_out = rdata_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence alert_edge_s;
    running && cfg_reg[KPCFG_ALERT_INT_EN_BIT] && cfg_reg[KPCFG_ALERT_NOW_BIT] && alert_fall;
  endsequence
  sequence key_sound_s;
    key_snd;
  endsequence

  // judged against the written bit, so a broken decode of the stored bit is caught
  timeout_bit_map_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    cfg_wr |=> bus_timeout_en_out == !$past(reg_wdata_in[KPCFG_TIMEOUT_DIS_BIT]))
    else $error("timeout enable wrong");
  src_ro_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    cfg_wr && !key_snd && !alert_snd && !serial_sound_in && !sound_done_in
    |=> src_reg == $past(src_reg)) else $error("source bits took write");
  cfg_store_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    cfg_wr |=> cfg_reg[7:3] == $past(reg_wdata_in[7:3]) && cfg_reg[0] == $past(reg_wdata_in[0]))
    else $error("config write lost");
  alert_now_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    alert_edge_s |=> alert_int_reg ##0 !int_n_out) else $error("immediate alert int missing");
  alert_off_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    !cfg_reg[KPCFG_ALERT_INT_EN_BIT] && !alert_wait_reg && !alert_int_reg |=> !alert_int_reg)
    else $error("alert int while disabled");
  key_sound_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    key_sound_s |=> sound_valid_out && sound_cmd_out == $past(key_sound_value_in)
    && src_reg == KPCFG_SRC_KEY) else $error("key sound not sent");
  alert_sound_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    alert_snd && !key_snd |=> sound_valid_out && sound_cmd_out == $past(alert_sound_value_in))
    else $error("alert sound not sent");
  shutdown_quiet_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    !running |-> int_n_out && !scan_run_out && !sounder_run_out) else $error("shutdown leak");
  // a pending or deferred alert must not survive a cycle of shutdown
  shutdown_clr_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    !running |=> !alert_wait_reg && !alert_int_reg) else $error("alert kept in shutdown");
  int_read_clr_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    int_rd && !(running && scan_int_tick_in && alert_wait_reg) && !alert_edge_s
    |=> !alert_int_reg) else $error("alert int not cleared by read");
  key_int_hold_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    key_int_reg && !fifo_empty_in |=> key_int_reg) else $error("key int dropped early");
endmodule

/* core/kpcfg_pkg.sv */
// constants for the keypad controller configuration register
//
// Contract
// - config bit 0 at 0 enables the serial bus timeout, 1 disables it.
// - bits 2:1 report sounder source: none, serial, key, alert.
// - bit 3 at 0 times alert interrupt with key scan, 1 immediately.
// - bit 4 at 1 lets alert falling edge interrupt; at 0 new edges do not, but an already deferred one still fires on the scan tick.
// - bit 5 at 1 sends alert sound value to sounder on alert fall.
// - bit 6 at 1 sends key sound value on every debounced key.
// - bit 7 at 0 stops scan, sounder timing and interrupts; ports stay usable.
// - bit 7 at 1 runs scanning and the sounder queue.
// - interrupt register read clears alert interrupt; key interrupt clears on empty FIFO.
package kpcfg_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] KPCFG_INT_ADDR = 8'h03;
  localparam logic [7:0] KPCFG_CFG_ADDR = 8'h04;
  localparam logic [7:0] KPCFG_CFG_RESET = 8'h01;
  // ------------------------------------------------------------
  // configuration fields
  // ------------------------------------------------------------
  localparam int KPCFG_TIMEOUT_DIS_BIT = 0;
  localparam int KPCFG_SRC_LO_BIT = 1;
  localparam int KPCFG_SRC_HI_BIT = 2;
  localparam int KPCFG_ALERT_NOW_BIT = 3;
  localparam int KPCFG_ALERT_INT_EN_BIT = 4;
  localparam int KPCFG_ALERT_SND_EN_BIT = 5;
  localparam int KPCFG_KEY_SND_EN_BIT = 6;
  localparam int KPCFG_RUN_BIT = 7;
  localparam logic [7:0] KPCFG_WRITE_MASK = 8'hf9;
  // interrupt register status bits
  localparam int KPCFG_INT_STAT_BIT = 7;
  localparam int KPCFG_INT_ALERT_BIT = 6;
  localparam int KPCFG_INT_KEY_BIT = 5;
  // ------------------------------------------------------------
  // sounder source codes
  // ------------------------------------------------------------
  localparam logic [1:0] KPCFG_SRC_NONE = 2'h0;
  localparam logic [1:0] KPCFG_SRC_SERIAL = 2'h1;
  localparam logic [1:0] KPCFG_SRC_KEY = 2'h2;
  localparam logic [1:0] KPCFG_SRC_ALERT = 2'h3;
endpackage

/* verification/kpcfg_sound_model.sv */
// sounder partner model: answers the latest command with a done pulse
`timescale 1ns/10ps
module kpcfg_sound_model #(
  parameter int DUR = 20
) (
  input wire logic clock_in,
  input wire logic sound_valid_in,
  output logic sound_done_out
);
  int cnt = 0;
  // a new command restarts the tone, so only the latest one reports done
  always @(posedge clock_in) begin
    sound_done_out <= (cnt == 1);
    if (sound_valid_in) begin
      cnt <= DUR;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  initial sound_done_out = 1'b0;
endmodule

/* verification/tb.sv */
// self-checking bench for the configuration register block
`timescale 1ns/10ps
module tb;
  import kpcfg_pkg::*;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, cmd;
  logic wr = 1'b0, rd = 1'b0, alert = 1'b1, key = 1'b0, tick = 1'b0, kint = 1'b0;
  logic empty = 1'b0, ser = 1'b0, done, sv, to_en, scan, snd, int_n;
  int n_errors = 0;
  int tests_run = 0;
  always #25 clock_in = ~clock_in;
  kpcfg_config_reg dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .reg_addr_in(addr),
    .reg_write_in(wr), .reg_wdata_in(wdata), .reg_read_in(rd), .reg_rdata_out(rdata),
    .alert_in(alert), .key_debounced_in(key), .scan_int_tick_in(tick), .key_int_in(kint),
    .fifo_empty_in(empty), .serial_sound_in(ser), .sound_done_in(done),
    .key_sound_value_in(8'h5b), .alert_sound_value_in(8'ha6), .sound_valid_out(sv),
    .sound_cmd_out(cmd), .bus_timeout_en_out(to_en), .scan_run_out(scan),
    .sounder_run_out(snd), .int_n_out(int_n));
  kpcfg_sound_model #(.DUR(20)) partner (.clock_in(clock_in), .sound_valid_in(sv),
    .sound_done_out(done));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  // inputs always move 1 ns after the edge so sampling never races
  task automatic step(input int n = 1);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step();
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    step();
    rd = 1'b0;
    chk(rdata, exp);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step();
    s = 1'b0;
  endtask
  // the command pulse lasts one cycle, so poll it cycle by cycle
  task automatic wait_sv();
    for (int i = 0; i < 4 && sv !== 1'b1; i++) step();
    if (sv !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: no sound command", $time);
      end_sim();
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    step(3);
    reset_n_in = 1'b1;
    rd_reg(KPCFG_CFG_ADDR, 8'h01);
    chk({to_en, scan, snd}, 8'h00);
    wr_reg(KPCFG_CFG_ADDR, 8'hff);
    rd_reg(KPCFG_CFG_ADDR, 8'hf9);
    chk({to_en, scan, snd}, 8'h03);
    wr_reg(KPCFG_CFG_ADDR, 8'h06);
    chk(to_en, 8'h01);
    wr_reg(8'h05, 8'hff);
    rd_reg(KPCFG_CFG_ADDR, 8'h00);
    $display("test register access done");
    wr_reg(KPCFG_CFG_ADDR, 8'hb8);
    alert = 1'b0;
    wait_sv();
    chk(cmd, 8'ha6);
    chk(int_n, 8'h00);
    step();
    rd_reg(KPCFG_CFG_ADDR, 8'hbe);
    rd_reg(KPCFG_INT_ADDR, 8'hc0);
    step();
    chk(int_n, 8'h01);
    alert = 1'b1;
    step(25);
    rd_reg(KPCFG_CFG_ADDR, 8'hb8);
    $display("test immediate alert done");
    wr_reg(KPCFG_CFG_ADDR, 8'h88);
    alert = 1'b0;
    pulse(tick);
    step(2);
    chk(int_n, 8'h01);
    alert = 1'b1;
    wr_reg(KPCFG_CFG_ADDR, 8'h90);
    alert = 1'b0;
    step(3);
    chk(int_n, 8'h01);
    pulse(tick);
    step();
    chk(int_n, 8'h00);
    rd_reg(KPCFG_INT_ADDR, 8'hc0);
    alert = 1'b1;
    $display("test timed alert done");
    wr_reg(KPCFG_CFG_ADDR, 8'hc0);
    pulse(key);
    wait_sv();
    chk(cmd, 8'h5b);
    step();
    rd_reg(KPCFG_CFG_ADDR, 8'hc4);
    pulse(ser);
    rd_reg(KPCFG_CFG_ADDR, 8'hc2);
    pulse(kint);
    rd_reg(KPCFG_INT_ADDR, 8'ha0);
    chk(int_n, 8'h00);
    empty = 1'b1;
    step(2);
    chk(int_n, 8'h01);
    $display("test key sound done");
    wr_reg(KPCFG_CFG_ADDR, 8'h78);
    alert = 1'b0;
    key = 1'b1;
    for (int i = 0; i < 3; i++) begin
      step();
      key = 1'b0;
      chk({scan, snd, int_n, sv}, 8'h02);
    end
    $display("test shutdown done");
    // a reset in mid-run must bring back the power-up value from the shutdown state the test above leaves
    reset_n_in = 1'b0;
    step(3);
    reset_n_in = 1'b1;
    rd_reg(KPCFG_CFG_ADDR, 8'h01);
    chk({to_en, scan, snd}, 8'h00);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule
